//--- hw/tam_pkg.sv
// Package with register map, field positions and reset values of the thermal alarm register map.
package tam_pkg;
  localparam logic [7:0] ADDR_LOCAL_VAL = 8'h00;
  localparam logic [7:0] ADDR_REM_VAL_H = 8'h01;
  localparam logic [7:0] ADDR_FLAGS1    = 8'h02;
  localparam logic [7:0] ADDR_CFG1_RD   = 8'h03;
  localparam logic [7:0] ADDR_RATE_RD   = 8'h04;
  localparam logic [7:0] ADDR_LUB_RD    = 8'h05;
  localparam logic [7:0] ADDR_LLB_RD    = 8'h06;
  localparam logic [7:0] ADDR_RUBH_RD   = 8'h07;
  localparam logic [7:0] ADDR_RLBH_RD   = 8'h08;
  localparam logic [7:0] ADDR_CFG1_WR   = 8'h09;
  localparam logic [7:0] ADDR_RATE_WR   = 8'h0A;
  localparam logic [7:0] ADDR_LUB_WR    = 8'h0B;
  localparam logic [7:0] ADDR_LLB_WR    = 8'h0C;
  localparam logic [7:0] ADDR_RUBH_WR   = 8'h0D;
  localparam logic [7:0] ADDR_RLBH_WR   = 8'h0E;
  localparam logic [7:0] ADDR_ONESHOT   = 8'h0F;
  localparam logic [7:0] ADDR_REM_VAL_L = 8'h10;
  localparam logic [7:0] ADDR_RTRIM_H   = 8'h11;
  localparam logic [7:0] ADDR_RTRIM_L   = 8'h12;
  localparam logic [7:0] ADDR_RUBL      = 8'h13;
  localparam logic [7:0] ADDR_RLBL      = 8'h14;
  localparam logic [7:0] ADDR_RTRIP     = 8'h19;
  localparam logic [7:0] ADDR_LTRIP     = 8'h20;
  localparam logic [7:0] ADDR_HYST      = 8'h21;
  localparam logic [7:0] ADDR_FQ        = 8'h22;
  localparam logic [7:0] ADDR_FLAGS2    = 8'h23;
  localparam logic [7:0] ADDR_CFG2      = 8'h24;
  localparam logic [7:0] ADDR_C2_VAL_H  = 8'h30;
  localparam logic [7:0] ADDR_C2_UBH    = 8'h31;
  localparam logic [7:0] ADDR_C2_LBH    = 8'h32;
  localparam logic [7:0] ADDR_C2_VAL_L  = 8'h33;
  localparam logic [7:0] ADDR_C2_TRIM_H = 8'h34;
  localparam logic [7:0] ADDR_C2_TRIM_L = 8'h35;
  localparam logic [7:0] ADDR_C2_UBL    = 8'h36;
  localparam logic [7:0] ADDR_C2_LBL    = 8'h37;
  localparam logic [7:0] ADDR_C2_TRIP   = 8'h39;
  localparam logic [7:0] ADDR_MAKER     = 8'h3D;
  localparam logic [7:0] ADDR_PART      = 8'h3E;

  localparam logic [7:0] RST_UPPER = 8'h55;
  localparam logic [7:0] RST_LOWER = 8'h00;
  localparam logic [7:0] RST_TRIP  = 8'h55;
  localparam logic [7:0] RST_HYST  = 8'h0A;
  localparam logic [7:0] RST_RATE  = 8'h07;
  localparam logic [7:0] RST_FQ    = 8'h01;
  localparam logic [7:0] RST_ZERO  = 8'h00;

  localparam int FQ_SCL_BIT   = 7;
  localparam int FQ_SDA_BIT   = 6;
  localparam int FQ_MASK_BIT  = 5;
  localparam int CFG1_SEL_BIT = 3;
  localparam logic [2:0] RUN_MAX = 3'h4;
endpackage : tam_pkg

//--- hw/tam_regmap.sv
// Register map, fault queue filter, status flags and alarm latch of the thermal alarm block.
`timescale 1ns/1ps
`default_nettype none
module tam_regmap #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
  parameter logic [7:0] PART_CODE  = 8'hA5  // Arbitrary value.
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 ptr_wr,
  input  wire logic [7:0]           ptr_wdata,
  input  wire logic                 data_wr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 rd_req,
  input  wire logic                 alert_service,
  input  wire logic                 meas_valid,
  input  wire logic [7:0]           meas_local,
  input  wire logic [7:0]           meas_r1_h,
  input  wire logic [7:0]           meas_r1_l,
  input  wire logic [7:0]           meas_r2_h,
  input  wire logic [7:0]           meas_r2_l,
  input  wire logic [1:0]           meas_open,
  output logic [7:0]                rd_data,
  output logic                      rd_valid,
  output logic                      oneshot_start,
  output logic                      scl_timeout_en,
  output logic                      sda_timeout_en,
  output logic [7:0]                primary_cfg,
  output logic [7:0]                conv_rate,
  output logic [7:0]                secondary_cfg,
  output logic                      alert_o,
  output logic                      alert_oe,
  output logic                      overtemp_trip_n
);
  import tam_pkg::*;

  logic [7:0] ptr_reg;
  logic [7:0] cfg1_reg, rate_reg, cfg2_reg, lub_reg, llb_reg, ltrip_reg, hyst_reg, fq_reg;
  logic [7:0] loc_val_reg;
  logic [7:0] rval_h_reg[2], rval_l_reg[2], rub_h_reg[2], rub_l_reg[2];
  logic [7:0] rlb_h_reg[2], rlb_l_reg[2], rtrim_h_reg[2], rtrim_l_reg[2], rtrip_reg[2];
  logic [2:0] run_reg[3];
  logic       hi_cond_reg[3], lo_cond_reg[3], hi_flag_reg[3], lo_flag_reg[3], trip_reg[3];
  logic [1:0] open_cond_reg, open_flag_reg;
  logic       latch_reg, oneshot_reg, rd_valid_reg, trip_n_reg;
  logic [7:0] rd_data_reg, rd_mux;
  logic       sh;
  logic [9:0] m10[3], ub10[3], lb10[3];
  logic [7:0] mh[3], tlim[3];
  logic       hi_now[3], lo_now[3], oor[3], qual[3], trip_next[3];
  logic [2:0] run_inc[3], thr;
  logic [8:0] tclr[3];
  logic       unmasked, rd_f1, rd_f2;

  function automatic logic [2:0] fq_threshold(input logic [7:0] fq);
    fq_threshold = {2'b00, fq[3]} + {2'b00, fq[2]} + {2'b00, fq[1]} + 3'h1;
  endfunction

  function automatic logic [9:0] rem10(input logic [7:0] h, input logic [7:0] l);
    rem10 = {h, l[7:6]};
  endfunction

  assign sh = cfg1_reg[CFG1_SEL_BIT];
  assign rd_f1 = rd_req && (ptr_reg == ADDR_FLAGS1);
  assign rd_f2 = rd_req && (ptr_reg == ADDR_FLAGS2);
  assign thr = fq_threshold(fq_reg);

  always_comb begin
    mh[0] = meas_local;
    mh[1] = meas_r1_h;
    mh[2] = meas_r2_h;
    m10[0] = {meas_local, 2'b00};
    m10[1] = rem10(meas_r1_h, meas_r1_l);
    m10[2] = rem10(meas_r2_h, meas_r2_l);
    ub10[0] = {lub_reg, 2'b00};
    lb10[0] = {llb_reg, 2'b00};
    tlim[0] = ltrip_reg;
    for (int i = 1; i < 3; i++) begin
      ub10[i] = rem10(rub_h_reg[i-1], rub_l_reg[i-1]);
      lb10[i] = rem10(rlb_h_reg[i-1], rlb_l_reg[i-1]);
      tlim[i] = rtrip_reg[i-1];
    end
    for (int i = 0; i < 3; i++) begin
      hi_now[i] = m10[i] > ub10[i];
      lo_now[i] = m10[i] < lb10[i];
      oor[i] = hi_now[i] || lo_now[i];
      run_inc[i] = (run_reg[i] == RUN_MAX) ? RUN_MAX : run_reg[i] + 3'h1;
      qual[i] = oor[i] && (run_inc[i] >= thr);
      tclr[i] = {1'b0, tlim[i]} - {1'b0, hyst_reg};
      trip_next[i] = trip_reg[i];
      if (mh[i] > tlim[i]) begin
        trip_next[i] = 1'b1;
      end else if (tclr[i][8] || ({1'b0, mh[i]} < tclr[i])) begin
        trip_next[i] = trip_reg[i] && !(({1'b0, mh[i]} < tclr[i]) && !tclr[i][8]);
      end
    end
  end

  assign unmasked = ((hi_flag_reg[0] || lo_flag_reg[0]) && !fq_reg[FQ_MASK_BIT])
                  || hi_flag_reg[1] || lo_flag_reg[1] || hi_flag_reg[2] || lo_flag_reg[2]
                  || (|open_flag_reg);

  always_ff @(posedge clock) begin
    if (rst) begin
      ptr_reg <= RST_ZERO;
    end else if (ptr_wr) begin
      ptr_reg <= ptr_wdata;
    end
  end

  // Host writes to the configuration, limit and trim registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg1_reg  <= RST_ZERO;
      cfg2_reg  <= RST_ZERO;
      rate_reg  <= RST_RATE;
      lub_reg   <= RST_UPPER;
      llb_reg   <= RST_LOWER;
      ltrip_reg <= RST_TRIP;
      hyst_reg  <= RST_HYST;
      fq_reg    <= RST_FQ;
      for (int i = 0; i < 2; i++) begin
        rub_h_reg[i]   <= RST_UPPER;
        rub_l_reg[i]   <= RST_ZERO;
        rlb_h_reg[i]   <= RST_LOWER;
        rlb_l_reg[i]   <= RST_ZERO;
        rtrim_h_reg[i] <= RST_ZERO;
        rtrim_l_reg[i] <= RST_ZERO;
        rtrip_reg[i]   <= RST_TRIP;
      end
    end else if (data_wr) begin
      case (ptr_reg)
        ADDR_CFG1_WR:   cfg1_reg <= wdata;
        ADDR_RATE_WR:   rate_reg <= wdata;
        ADDR_LUB_WR:    lub_reg <= wdata;
        ADDR_LLB_WR:    llb_reg <= wdata;
        ADDR_RUBH_WR:   rub_h_reg[sh] <= wdata;
        ADDR_RLBH_WR:   rlb_h_reg[sh] <= wdata;
        ADDR_RTRIM_H:   rtrim_h_reg[sh] <= wdata;
        ADDR_RTRIM_L:   rtrim_l_reg[sh] <= wdata;
        ADDR_RUBL:      rub_l_reg[sh] <= wdata;
        ADDR_RLBL:      rlb_l_reg[sh] <= wdata;
        ADDR_RTRIP:     rtrip_reg[sh] <= wdata;
        ADDR_LTRIP:     ltrip_reg <= wdata;
        ADDR_HYST:      hyst_reg <= wdata;
        ADDR_FQ:        fq_reg <= wdata;
        ADDR_CFG2:      cfg2_reg <= wdata;
        ADDR_C2_UBH:    rub_h_reg[1] <= wdata;
        ADDR_C2_LBH:    rlb_h_reg[1] <= wdata;
        ADDR_C2_TRIM_H: rtrim_h_reg[1] <= wdata;
        ADDR_C2_TRIM_L: rtrim_l_reg[1] <= wdata;
        ADDR_C2_UBL:    rub_l_reg[1] <= wdata;
        ADDR_C2_LBL:    rlb_l_reg[1] <= wdata;
        ADDR_C2_TRIP:   rtrip_reg[1] <= wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      oneshot_reg <= 1'b0;
    end else begin
      oneshot_reg <= data_wr && (ptr_reg == ADDR_ONESHOT);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      loc_val_reg <= RST_ZERO;
      for (int i = 0; i < 2; i++) begin
        rval_h_reg[i] <= RST_ZERO;
        rval_l_reg[i] <= RST_ZERO;
      end
    end else if (meas_valid) begin
      loc_val_reg   <= meas_local;
      rval_h_reg[0] <= meas_r1_h;
      rval_l_reg[0] <= meas_r1_l;
      rval_h_reg[1] <= meas_r2_h;
      rval_l_reg[1] <= meas_r2_l;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        run_reg[i]     <= 3'h0;
        hi_cond_reg[i] <= 1'b0;
        lo_cond_reg[i] <= 1'b0;
        trip_reg[i]    <= 1'b0;
      end
      open_cond_reg <= 2'b00;
    end else if (meas_valid) begin
      for (int i = 0; i < 3; i++) begin
        run_reg[i]     <= oor[i] ? run_inc[i] : 3'h0;
        hi_cond_reg[i] <= hi_now[i];
        lo_cond_reg[i] <= lo_now[i];
        trip_reg[i]    <= trip_next[i];
      end
      open_cond_reg <= meas_open;
    end
  end

  // Sticky flags: a new qualified event wins over a status-read clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        hi_flag_reg[i] <= 1'b0;
        lo_flag_reg[i] <= 1'b0;
      end
      open_flag_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (meas_valid && qual[i] && hi_now[i]) begin
          hi_flag_reg[i] <= 1'b1;
        end else if (((i < 2) ? rd_f1 : rd_f2) && !hi_cond_reg[i]) begin
          hi_flag_reg[i] <= 1'b0;
        end
        if (meas_valid && qual[i] && lo_now[i]) begin
          lo_flag_reg[i] <= 1'b1;
        end else if (((i < 2) ? rd_f1 : rd_f2) && !lo_cond_reg[i]) begin
          lo_flag_reg[i] <= 1'b0;
        end
      end
      for (int j = 0; j < 2; j++) begin
        if (meas_valid && meas_open[j]) begin
          open_flag_reg[j] <= 1'b1;
        end else if (((j == 0) ? rd_f1 : rd_f2) && !open_cond_reg[j]) begin
          open_flag_reg[j] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      latch_reg <= 1'b0;
    end else if (unmasked) begin
      latch_reg <= 1'b1;
    end else if (alert_service) begin
      latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      trip_n_reg <= 1'b1;
    end else begin
      trip_n_reg <= !(trip_reg[0] || trip_reg[1] || trip_reg[2]);
    end
  end

  always_comb begin
    rd_mux = RST_ZERO;
    case (ptr_reg)
      ADDR_LOCAL_VAL: rd_mux = loc_val_reg;
      ADDR_REM_VAL_H: rd_mux = rval_h_reg[sh];
      ADDR_FLAGS1:    rd_mux = {1'b0, hi_flag_reg[0], lo_flag_reg[0], hi_flag_reg[1],
                                lo_flag_reg[1], open_flag_reg[0], trip_reg[1], trip_reg[0]};
      ADDR_CFG1_RD:   rd_mux = cfg1_reg;
      ADDR_RATE_RD:   rd_mux = rate_reg;
      ADDR_LUB_RD:    rd_mux = lub_reg;
      ADDR_LLB_RD:    rd_mux = llb_reg;
      ADDR_RUBH_RD:   rd_mux = rub_h_reg[sh];
      ADDR_RLBH_RD:   rd_mux = rlb_h_reg[sh];
      ADDR_REM_VAL_L: rd_mux = rval_l_reg[sh];
      ADDR_RTRIM_H:   rd_mux = rtrim_h_reg[sh];
      ADDR_RTRIM_L:   rd_mux = rtrim_l_reg[sh];
      ADDR_RUBL:      rd_mux = rub_l_reg[sh];
      ADDR_RLBL:      rd_mux = rlb_l_reg[sh];
      ADDR_RTRIP:     rd_mux = rtrip_reg[sh];
      ADDR_LTRIP:     rd_mux = ltrip_reg;
      ADDR_HYST:      rd_mux = hyst_reg;
      ADDR_FQ:        rd_mux = fq_reg;
      ADDR_FLAGS2:    rd_mux = {3'b000, hi_flag_reg[2], lo_flag_reg[2], open_flag_reg[1],
                                trip_reg[2], latch_reg};
      ADDR_CFG2:      rd_mux = cfg2_reg;
      ADDR_C2_VAL_H:  rd_mux = rval_h_reg[1];
      ADDR_C2_UBH:    rd_mux = rub_h_reg[1];
      ADDR_C2_LBH:    rd_mux = rlb_h_reg[1];
      ADDR_C2_VAL_L:  rd_mux = rval_l_reg[1];
      ADDR_C2_TRIM_H: rd_mux = rtrim_h_reg[1];
      ADDR_C2_TRIM_L: rd_mux = rtrim_l_reg[1];
      ADDR_C2_UBL:    rd_mux = rub_l_reg[1];
      ADDR_C2_LBL:    rd_mux = rlb_l_reg[1];
      ADDR_C2_TRIP:   rd_mux = rtrip_reg[1];
      ADDR_MAKER:     rd_mux = MAKER_CODE;
      ADDR_PART:      rd_mux = PART_CODE;
      default:        rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_reg  <= RST_ZERO;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_req;
      if (rd_req) begin
        rd_data_reg <= rd_mux;
      end
    end
  end

  assign rd_data         = rd_data_reg;
  assign rd_valid        = rd_valid_reg;
  assign oneshot_start   = oneshot_reg;
  assign scl_timeout_en  = fq_reg[FQ_SCL_BIT];
  assign sda_timeout_en  = fq_reg[FQ_SDA_BIT];
  assign primary_cfg     = cfg1_reg;
  assign conv_rate       = rate_reg;
  assign secondary_cfg   = cfg2_reg;
  assign alert_o         = 1'b0;
  assign alert_oe        = latch_reg;
  assign overtemp_trip_n = trip_n_reg;

  a_fq_default: assert property (@(posedge clock) $past(rst) && !rst |-> fq_reg == RST_FQ)
    else $error("fault queue default wrong");
  a_run_of_one: assert property (@(posedge clock) disable iff (rst)
    meas_valid && fq_reg[3:1] == 3'b000 && hi_now[0] |=> hi_flag_reg[0])
    else $error("single run did not flag");
  a_scl_enable: assert property (@(posedge clock) disable iff (rst)
    data_wr && ptr_reg == ADDR_FQ |=> scl_timeout_en == $past(wdata[7]))
    else $error("scl timeout enable not taken");
  a_sda_enable: assert property (@(posedge clock) disable iff (rst)
    data_wr && ptr_reg == ADDR_FQ |=> sda_timeout_en == $past(wdata[6]))
    else $error("sda timeout enable not taken");
  a_local_masked: assert property (@(posedge clock) disable iff (rst)
    fq_reg[FQ_MASK_BIT] && !latch_reg && !alert_service && !(|open_flag_reg)
    && !hi_flag_reg[1] && !lo_flag_reg[1] && !hi_flag_reg[2] && !lo_flag_reg[2]
    |=> !latch_reg)
    else $error("masked local flag raised alarm");
  a_split_write: assert property (@(posedge clock) disable iff (rst)
    data_wr && ptr_reg == ADDR_CFG1_RD && !ptr_wr |=> $stable(cfg1_reg))
    else $error("read address accepted a write");
  a_shared_read: assert property (@(posedge clock) disable iff (rst)
    rd_req && ptr_reg == ADDR_RUBH_RD |=> rd_data == $past(rub_h_reg[sh]))
    else $error("shared read took wrong channel");
  a_oneshot_pulse: assert property (@(posedge clock) disable iff (rst)
    data_wr && ptr_reg == ADDR_ONESHOT |=> oneshot_start ##1 !oneshot_start || $past(data_wr))
    else $error("one-shot strobe missing");
  a_value_readonly: assert property (@(posedge clock) disable iff (rst)
    data_wr && ptr_reg == ADDR_LOCAL_VAL && !meas_valid |=> $stable(loc_val_reg))
    else $error("value register took a write");
  a_direct_chan2: assert property (@(posedge clock) disable iff (rst)
    data_wr && ptr_reg == ADDR_C2_UBH |=> rub_h_reg[1] == $past(wdata))
    else $error("direct channel 2 write lost");
  a_reset_values: assert property (@(posedge clock) $past(rst) && !rst
    |-> rub_h_reg[0] == RST_UPPER && hyst_reg == RST_HYST && rate_reg == RST_RATE)
    else $error("power-on defaults wrong");
  a_alarm_set: assert property (@(posedge clock) disable iff (rst)
    unmasked |=> alert_oe)
    else $error("alarm not driven");
  a_alarm_hold: assert property (@(posedge clock) disable iff (rst)
    latch_reg && !alert_service |=> latch_reg [*1] ##0 alert_oe)
    else $error("alarm cleared without service");
  a_run_restart: assert property (@(posedge clock) disable iff (rst)
    meas_valid && !oor[1] |=> run_reg[1] == 3'h0)
    else $error("run counter kept after in-limit");

  c_alarm_served: cover property (@(posedge clock) disable iff (rst)
    latch_reg ##1 alert_service ##1 !latch_reg);
  c_run_of_four: cover property (@(posedge clock) disable iff (rst)
    fq_reg[3:1] == 3'b111 && run_reg[0] == RUN_MAX);
  c_oneshot: cover property (@(posedge clock) disable iff (rst) oneshot_start);
endmodule // tam_regmap
`default_nettype wire

//--- tb/tam_host.sv
// Bus host model that loads the pointer, writes registers and reads them back.
`timescale 1ns/1ps
`default_nettype none
module tam_host (
  input  wire logic       clock,
  output logic            ptr_wr,
  output logic [7:0]      ptr_wdata,
  output logic            data_wr,
  output logic [7:0]      wdata,
  output logic            rd_req,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial begin
    ptr_wr    = 1'b0;
    ptr_wdata = 8'h00;
    data_wr   = 1'b0;
    wdata     = 8'h00;
    rd_req    = 1'b0;
  end

  // Released byte lanes show the inverse of the last byte, never a stale copy.
  task automatic set_ptr(input logic [7:0] a);
    @(posedge clock);
    ptr_wr    <= 1'b1;
    ptr_wdata <= a;
    @(posedge clock);
    ptr_wr    <= 1'b0;
    ptr_wdata <= ~a;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    set_ptr(a);
    data_wr <= 1'b1;
    wdata   <= d;
    @(posedge clock);
    data_wr <= 1'b0;
    wdata   <= ~d;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    int i;
    set_ptr(a);
    rd_req <= 1'b1;
    @(posedge clock);
    rd_req <= 1'b0;
    d = 8'hxx;
    for (i = 0; i < 4; i++) begin
      #1;
      if (rd_valid === 1'b1) begin
        d = rd_data;
        break;
      end
      @(posedge clock);
    end
  endtask
endmodule // tam_host
`default_nettype wire

//--- tb/tb.sv
// Self-checking testbench of the thermal alarm register map.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tam_pkg::*;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       ptr_wr, data_wr, rd_req, rd_valid, oneshot_start;
  logic [7:0] ptr_wdata, wdata, rd_data, v;
  logic       alert_service = 1'b0;
  logic       meas_valid = 1'b0;
  logic [7:0] meas_local = 8'h00;
  logic       scl_en, sda_en, alert_oe;
  logic       alert_o, trip_n;
  logic [7:0] pcfg, rate_o, scfg;
  logic [1:0] open_r = 2'b00;
  int         err_total = 0;
  int         n_tests = 0;
  int         n_os = 0;
  int         i;

  initial begin
    forever #5 clock = ~clock;
  end

  tam_host i_host (.clock(clock), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .data_wr(data_wr),
    .wdata(wdata), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));

  tam_regmap i_dut (.clock(clock), .rst(rst), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata),
    .data_wr(data_wr), .wdata(wdata), .rd_req(rd_req), .alert_service(alert_service),
    .meas_valid(meas_valid), .meas_local(meas_local), .meas_r1_h(8'h00), .meas_r1_l(8'h00),
    .meas_r2_h(8'h00), .meas_r2_l(8'h00), .meas_open(open_r), .rd_data(rd_data),
    .rd_valid(rd_valid), .oneshot_start(oneshot_start), .scl_timeout_en(scl_en),
    .sda_timeout_en(sda_en), .primary_cfg(pcfg), .conv_rate(rate_o), .secondary_cfg(scfg),
    .alert_o(alert_o), .alert_oe(alert_oe), .overtemp_trip_n(trip_n));

  always @(posedge clock) begin
    if (oneshot_start === 1'b1) n_os++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd_reg(a, d);
    chk(d, exp, $sformatf("read %h", a));
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
  endtask

  task automatic meas(input logic [7:0] l);
    @(posedge clock);
    meas_valid <= 1'b1;
    meas_local <= l;
    @(posedge clock);
    meas_valid <= 1'b0;
    meas_local <= ~l;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic chk_alert(input logic e, input string m);
    chk({6'h00, alert_o, alert_oe}, {7'h00, e}, m);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    static logic [7:0] ra [14] = '{ADDR_CFG1_RD, ADDR_RATE_RD, ADDR_LUB_RD, ADDR_LLB_RD,
      ADDR_RUBH_RD,
      ADDR_RLBH_RD, ADDR_RTRIP, ADDR_LTRIP, ADDR_HYST, ADDR_FQ, ADDR_FLAGS2, ADDR_CFG2,
      ADDR_C2_UBH, ADDR_C2_TRIP};
    static logic [7:0] rv [14] = '{8'h00, 8'h07, 8'h55, 8'h00, 8'h55, 8'h00, 8'h55, 8'h55,
      8'h0A,
      8'h01, 8'h00, 8'h00, 8'h55, 8'h55};
    static logic [7:0] fq [3] = '{8'h02, 8'h06, 8'h0E};
    do_reset();
    for (i = 0; i < 14; i++) rd_chk(ra[i], rv[i]);
    chk(rate_o, 8'h07, "rate output default");
    chk(pcfg, 8'h00, "primary config output default");
    chk(scfg, 8'h00, "secondary config output default");
    chk({7'h00, trip_n}, 8'h01, "no trip after reset");
    $display("test reset_values done");

    i_host.wr_reg(ADDR_LUB_WR, 8'h66);
    rd_chk(ADDR_LUB_RD, 8'h66);
    i_host.wr_reg(ADDR_LUB_RD, 8'h11);
    rd_chk(ADDR_LUB_RD, 8'h66);
    rd_chk(ADDR_LUB_WR, 8'h00);
    i_host.wr_reg(ADDR_LOCAL_VAL, 8'hFF);
    rd_chk(ADDR_LOCAL_VAL, 8'h00);
    i_host.wr_reg(ADDR_FLAGS2, 8'hFF);
    rd_chk(ADDR_FLAGS2, 8'h00);
    $display("test split_and_readonly done");

    i_host.wr_reg(ADDR_FQ, 8'hC5);
    #1;
    chk({6'h00, scl_en, sda_en}, 8'h03, "timeouts on");
    rd_chk(ADDR_FQ, 8'hC5);
    i_host.wr_reg(ADDR_FQ, 8'h41);
    #1;
    chk({6'h00, scl_en, sda_en}, 8'h01, "scl off sda on");
    i_host.wr_reg(ADDR_ONESHOT, 8'hA7);
    repeat (2) @(posedge clock);
    chk(n_os[7:0], 8'h01, "one measurement started");
    rd_chk(ADDR_ONESHOT, 8'h00);
    $display("test fault_queue_bits done");

    i_host.wr_reg(ADDR_C2_UBH, 8'h70);
    i_host.wr_reg(ADDR_CFG1_WR, 8'h08);
    #1;
    chk(pcfg, 8'h08, "config output follows write");
    rd_chk(ADDR_RUBH_RD, 8'h70);
    i_host.wr_reg(ADDR_RUBH_WR, 8'h33);
    rd_chk(ADDR_C2_UBH, 8'h33);
    i_host.wr_reg(ADDR_CFG1_WR, 8'h00);
    rd_chk(ADDR_RUBH_RD, 8'h55);
    rd_chk(ADDR_C2_UBH, 8'h33);
    $display("test channel_select done");

    do_reset();
    meas(8'h60);
    chk_alert(1'b1, "alarm after one");
    chk({7'h00, trip_n}, 8'h00, "trip above default limit");
    rd_chk(ADDR_FLAGS2, 8'h01);
    rd_chk(ADDR_FLAGS1, 8'h41);
    chk_alert(1'b1, "status read keeps alarm");
    meas(8'h20);
    chk({7'h00, trip_n}, 8'h01, "trip released below hysteresis");
    rd_chk(ADDR_FLAGS1, 8'h40);
    rd_chk(ADDR_FLAGS1, 8'h00);
    @(posedge clock);
    alert_service <= 1'b1;
    @(posedge clock);
    alert_service <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk_alert(1'b0, "serviced alarm clears");
    @(posedge clock);
    open_r <= 2'b10;
    meas(8'h20);
    @(posedge clock);
    open_r <= 2'b00;
    rd_chk(ADDR_FLAGS2, 8'h05);
    chk_alert(1'b1, "open sensor raises alarm");
    $display("test alarm_latch done");

    for (int k = 0; k < 3; k++) begin
      do_reset();
      i_host.wr_reg(ADDR_FQ, fq[k]);
      repeat (k + 1) meas(8'h60);
      chk_alert(1'b0, "run too short");
      meas(8'h60);
      chk_alert(1'b1, "run reaches count");
    end
    do_reset();
    i_host.wr_reg(ADDR_FQ, 8'h02);
    meas(8'h60);
    meas(8'h20);
    meas(8'h60);
    chk_alert(1'b0, "broken run restarts");
    do_reset();
    i_host.wr_reg(ADDR_FQ, 8'h21);
    meas(8'h60);
    chk_alert(1'b0, "local alarm masked");
    do_reset();
    i_host.wr_reg(ADDR_FQ, 8'h10);
    meas(8'h60);
    chk_alert(1'b1, "reserved bit inert");
    $display("test consecutive_runs done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
